// ==== common/vmd_pkg.sv ====
package vmd_pkg;

    // Parameter object sub-indices.
    localparam logic [7:0] IDX_HOLD_DUTY   = 8'h0A;
    localparam logic [7:0] IDX_RUN_DUTY    = 8'h0B;
    localparam logic [7:0] IDX_ACCEL_DUTY  = 8'h0C;
    localparam logic [7:0] IDX_DECEL_DUTY  = 8'h0D;
    localparam logic [7:0] IDX_CROSSOVER   = 8'h0E;
    localparam logic [7:0] IDX_START_SLOPE = 8'h0F;
    localparam logic [7:0] IDX_FINAL_ACCEL = 8'h10;
    localparam logic [7:0] IDX_FINAL_DECEL = 8'h11;
    localparam logic [7:0] IDX_THERMAL     = 8'h12;
    localparam logic [7:0] IDX_STALL_TH    = 8'h13;

    // Field widths.
    localparam int DUTY_W  = 8;
    localparam int SPEED_W = 14;
    localparam int SLOPE_W = 8;
    localparam int THERM_W = 4;
    localparam int DATA_W  = 16;

    // Reset values.
    localparam logic [7:0]  RST_HOLD_DUTY   = 8'h05;
    localparam logic [7:0]  RST_RUN_DUTY    = 8'h07;
    localparam logic [7:0]  RST_ACCEL_DUTY  = 8'h07;
    localparam logic [7:0]  RST_DECEL_DUTY  = 8'h07;
    localparam logic [13:0] RST_CROSSOVER   = 14'h0F05;
    localparam logic [7:0]  RST_START_SLOPE = 8'h0F;
    localparam logic [7:0]  RST_FINAL_ACCEL = 8'h17;
    localparam logic [7:0]  RST_FINAL_DECEL = 8'h17;
    localparam logic [3:0]  RST_THERMAL     = 4'h0;
    localparam logic [15:0] RST_STALL_TH    = 16'h40DA;

    // Stall threshold grid in milliamperes.
    localparam logic [15:0] STALL_STEP_MA  = 16'h03D1;
    localparam logic [5:0]  STALL_CODE_MIN = 6'h01;
    localparam logic [5:0]  STALL_CODE_MAX = 6'h1F;

    // Thermal factor is (THERM_BASE + code) / 2^THERM_SHIFT.
    localparam logic [5:0] THERM_BASE  = 6'h20;
    localparam int         THERM_SHIFT = 5;

    // Scaling of slope times speed onto the duty code.
    localparam int COMP_SHIFT = 12;

    // Speed tick timing.
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS       = 250;
    localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Motion phase, coded as the motor status field; Gray along hold-accel-run-brake.
    typedef enum logic [1:0] {
        VMD_PH_HOLD  = 2'h0,
        VMD_PH_ACCEL = 2'h1,
        VMD_PH_RUN   = 2'h3,
        VMD_PH_BRAKE = 2'h2
    } vmd_phase_t;

endpackage : vmd_pkg

// ==== logic/vmd_pwm.sv ====
`timescale 1ns/1ps
module vmd_pwm #(
    parameter int DUTY_W = 8
) (
    // Clock and reset.
    input  wire logic              clk_in,
    input  wire logic              sys_rst_in,
    // Control.
    input  wire logic              enable_in,
    input  wire logic [DUTY_W-1:0] duty_in,
    // Modulator output.
    output logic                   pwm_out
);

    logic [DUTY_W-1:0] cnt_q;
    logic [DUTY_W-1:0] cnt_d;
    logic [DUTY_W-1:0] duty_hold_q;
    logic [DUTY_W-1:0] duty_hold_d;
    logic              pwm_q;
    logic              pwm_d;

    // The duty is taken only at the period end so that a change never cuts a pulse short.
    always_comb begin
        cnt_d       = cnt_q + 1'b1;
        duty_hold_d = duty_hold_q;
        if (cnt_q == {DUTY_W{1'b1}}) begin
            duty_hold_d = duty_in;
        end
        pwm_d = enable_in && (cnt_d < duty_hold_d);
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cnt_q       <= '0;
            duty_hold_q <= '0;
            pwm_q       <= 1'b0;
        end else begin
            cnt_q       <= cnt_d;
            duty_hold_q <= duty_hold_d;
            pwm_q       <= pwm_d;
        end
    end

    assign pwm_out = pwm_q;

endmodule : vmd_pwm

// ==== logic/vmd_bemf_comp.sv ====
`timescale 1ns/1ps
module vmd_bemf_comp #(
    parameter int SPEED_W = 14
) (
    // Operating point.
    input  wire logic [7:0]         duty_level_in,
    input  wire logic [SPEED_W-1:0] speed_in,
    // Curve settings.
    input  wire logic [SPEED_W-1:0] cross_in,
    input  wire logic [7:0]         start_slope_in,
    input  wire logic [7:0]         final_slope_in,
    input  wire logic [3:0]         therm_in,
    // Result.
    output logic [7:0]              duty_out,
    output logic                    above_out
);

    localparam int PW = SPEED_W + 9;

    logic [PW-1:0] seg_lo;
    logic [PW-1:0] seg_hi;
    logic [PW-1:0] sum;
    logic [7:0]    comp;
    logic [13:0]   scaled;
    logic [8:0]    therm_val;

    always_comb begin
        above_out = (speed_in >= cross_in);
        if (above_out) begin
            seg_lo = PW'(start_slope_in) * PW'(cross_in);
            seg_hi = PW'(final_slope_in) * PW'(speed_in - cross_in);
        end else begin
            seg_lo = PW'(start_slope_in) * PW'(speed_in);
            seg_hi = '0;
        end
        sum       = PW'(duty_level_in) + ((seg_lo + seg_hi) >> vmd_pkg::COMP_SHIFT);
        comp      = (sum > PW'(8'hFF)) ? 8'hFF : sum[7:0];
        scaled    = 14'(comp) * 14'(vmd_pkg::THERM_BASE + 6'(therm_in));
        therm_val = scaled[vmd_pkg::THERM_SHIFT +: 9];
        duty_out  = (therm_val > 9'h0FF) ? 8'hFF : therm_val[7:0];
    end

endmodule : vmd_bemf_comp

// ==== logic/vmd_drive_params.sv ====
`timescale 1ns/1ps
module vmd_drive_params #(
    parameter int SPEED_W = vmd_pkg::SPEED_W
) (
    // Clock and reset.
    input  wire logic               clk_in,
    input  wire logic               sys_rst_in,
    // Parameter access port.
    input  wire logic               param_wr_in,
    input  wire logic               param_rd_in,
    input  wire logic [7:0]         param_idx_in,
    input  wire logic [15:0]        param_wdata_in,
    output logic [15:0]             param_rdata_out,
    output logic                    param_ack_out,
    output logic                    param_err_out,
    // Motion state.
    input  wire logic               voltage_mode_in,
    input  wire logic [1:0]         motion_phase_in,
    input  wire logic [SPEED_W-1:0] speed_in,
    // Stall detectors.
    input  wire logic               stall_a_raw_in,
    input  wire logic               stall_b_raw_in,
    output logic                    stall_a_out,
    output logic                    stall_b_out,
    output logic [15:0]             stall_threshold_out,
    // Output stage.
    output logic [7:0]              duty_out,
    output logic                    above_crossover_out,
    output logic                    pwm_out
);

    localparam int TICK_CNT_W = $clog2(vmd_pkg::TICK_CYCLES);
    localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(vmd_pkg::TICK_CYCLES - 1);

    // Decoding of the sub-index is shared by the read and write paths.
    function automatic logic idx_mapped(input logic [7:0] idx);
        idx_mapped = (idx >= vmd_pkg::IDX_HOLD_DUTY) && (idx <= vmd_pkg::IDX_STALL_TH);
    endfunction : idx_mapped

    // Snap a requested current to the grid; out-of-range requests clamp to the ends.
    function automatic logic [15:0] stall_quantize(input logic [15:0] ma);
        logic [15:0] code;
        code = ma / vmd_pkg::STALL_STEP_MA;
        if (code < 16'(vmd_pkg::STALL_CODE_MIN)) begin
            code = 16'(vmd_pkg::STALL_CODE_MIN);
        end else if (code > 16'(vmd_pkg::STALL_CODE_MAX)) begin
            code = 16'(vmd_pkg::STALL_CODE_MAX);
        end
        stall_quantize = 16'(code * vmd_pkg::STALL_STEP_MA);
    endfunction : stall_quantize

    // Parameter storage.
    logic [7:0]         hold_duty_level_q;
    logic [7:0]         hold_duty_level_d;
    logic [7:0]         run_duty_level_q;
    logic [7:0]         run_duty_level_d;
    logic [7:0]         accel_duty_level_q;
    logic [7:0]         accel_duty_level_d;
    logic [7:0]         decel_duty_level_q;
    logic [7:0]         decel_duty_level_d;
    logic [13:0]        comp_crossover_speed_q;
    logic [13:0]        comp_crossover_speed_d;
    logic [7:0]         start_comp_slope_q;
    logic [7:0]         start_comp_slope_d;
    logic [7:0]         final_comp_slope_accel_q;
    logic [7:0]         final_comp_slope_accel_d;
    logic [7:0]         final_comp_slope_decel_q;
    logic [7:0]         final_comp_slope_decel_d;
    logic [3:0]         thermal_comp_factor_q;
    logic [3:0]         thermal_comp_factor_d;
    logic [15:0]        stall_current_threshold_q;
    logic [15:0]        stall_current_threshold_d;

    // Access port answer.
    logic [15:0]        rdata_q;
    logic [15:0]        rdata_d;
    logic               ack_q;
    logic               ack_d;
    logic               err_q;
    logic               err_d;

    // Speed sampling and output state.
    logic [TICK_CNT_W-1:0] tick_cnt_q;
    logic [TICK_CNT_W-1:0] tick_cnt_d;
    logic [SPEED_W-1:0] speed_q;
    logic [SPEED_W-1:0] speed_d;
    logic [7:0]         duty_q;
    logic [7:0]         duty_d;
    logic               above_q;
    logic               above_d;
    logic               stall_a_q;
    logic               stall_a_d;
    logic               stall_b_q;
    logic               stall_b_d;

    vmd_pkg::vmd_phase_t phase;
    logic [7:0]         phase_duty;
    logic [7:0]         phase_final_slope;
    logic [7:0]         comp_duty;
    logic               comp_above;

    // Register writes; a write to an unmapped index changes nothing.
    always_comb begin
        hold_duty_level_d         = hold_duty_level_q;
        run_duty_level_d          = run_duty_level_q;
        accel_duty_level_d        = accel_duty_level_q;
        decel_duty_level_d        = decel_duty_level_q;
        comp_crossover_speed_d    = comp_crossover_speed_q;
        start_comp_slope_d        = start_comp_slope_q;
        final_comp_slope_accel_d  = final_comp_slope_accel_q;
        final_comp_slope_decel_d  = final_comp_slope_decel_q;
        thermal_comp_factor_d     = thermal_comp_factor_q;
        stall_current_threshold_d = stall_current_threshold_q;
        if (param_wr_in) begin
            if (param_idx_in == vmd_pkg::IDX_HOLD_DUTY) begin
                hold_duty_level_d = param_wdata_in[7:0];
            end else if (param_idx_in == vmd_pkg::IDX_RUN_DUTY) begin
                run_duty_level_d = param_wdata_in[7:0];
            end else if (param_idx_in == vmd_pkg::IDX_ACCEL_DUTY) begin
                accel_duty_level_d = param_wdata_in[7:0];
            end else if (param_idx_in == vmd_pkg::IDX_DECEL_DUTY) begin
                decel_duty_level_d = param_wdata_in[7:0];
            end else if (param_idx_in == vmd_pkg::IDX_CROSSOVER) begin
                comp_crossover_speed_d = param_wdata_in[13:0];
            end else if (param_idx_in == vmd_pkg::IDX_START_SLOPE) begin
                start_comp_slope_d = param_wdata_in[7:0];
            end else if (param_idx_in == vmd_pkg::IDX_FINAL_ACCEL) begin
                final_comp_slope_accel_d = param_wdata_in[7:0];
            end else if (param_idx_in == vmd_pkg::IDX_FINAL_DECEL) begin
                final_comp_slope_decel_d = param_wdata_in[7:0];
            end else if (param_idx_in == vmd_pkg::IDX_THERMAL) begin
                thermal_comp_factor_d = param_wdata_in[3:0];
            end else if (param_idx_in == vmd_pkg::IDX_STALL_TH) begin
                stall_current_threshold_d = stall_quantize(param_wdata_in);
            end
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            hold_duty_level_q         <= vmd_pkg::RST_HOLD_DUTY;
            run_duty_level_q          <= vmd_pkg::RST_RUN_DUTY;
            accel_duty_level_q        <= vmd_pkg::RST_ACCEL_DUTY;
            decel_duty_level_q        <= vmd_pkg::RST_DECEL_DUTY;
            comp_crossover_speed_q    <= vmd_pkg::RST_CROSSOVER;
            start_comp_slope_q        <= vmd_pkg::RST_START_SLOPE;
            final_comp_slope_accel_q  <= vmd_pkg::RST_FINAL_ACCEL;
            final_comp_slope_decel_q  <= vmd_pkg::RST_FINAL_DECEL;
            thermal_comp_factor_q     <= vmd_pkg::RST_THERMAL;
            stall_current_threshold_q <= vmd_pkg::RST_STALL_TH;
        end else begin
            hold_duty_level_q         <= hold_duty_level_d;
            run_duty_level_q          <= run_duty_level_d;
            accel_duty_level_q        <= accel_duty_level_d;
            decel_duty_level_q        <= decel_duty_level_d;
            comp_crossover_speed_q    <= comp_crossover_speed_d;
            start_comp_slope_q        <= start_comp_slope_d;
            final_comp_slope_accel_q  <= final_comp_slope_accel_d;
            final_comp_slope_decel_q  <= final_comp_slope_decel_d;
            thermal_comp_factor_q     <= thermal_comp_factor_d;
            stall_current_threshold_q <= stall_current_threshold_d;
        end
    end

    // Read answer one cycle after the request; narrow fields read zero above their width.
    always_comb begin
        rdata_d = rdata_q;
        ack_d   = param_wr_in || param_rd_in;
        err_d   = (param_wr_in || param_rd_in) && !idx_mapped(param_idx_in);
        if (param_rd_in) begin
            if (param_idx_in == vmd_pkg::IDX_HOLD_DUTY) begin
                rdata_d = {8'h00, hold_duty_level_q};
            end else if (param_idx_in == vmd_pkg::IDX_RUN_DUTY) begin
                rdata_d = {8'h00, run_duty_level_q};
            end else if (param_idx_in == vmd_pkg::IDX_ACCEL_DUTY) begin
                rdata_d = {8'h00, accel_duty_level_q};
            end else if (param_idx_in == vmd_pkg::IDX_DECEL_DUTY) begin
                rdata_d = {8'h00, decel_duty_level_q};
            end else if (param_idx_in == vmd_pkg::IDX_CROSSOVER) begin
                rdata_d = {2'h0, comp_crossover_speed_q};
            end else if (param_idx_in == vmd_pkg::IDX_START_SLOPE) begin
                rdata_d = {8'h00, start_comp_slope_q};
            end else if (param_idx_in == vmd_pkg::IDX_FINAL_ACCEL) begin
                rdata_d = {8'h00, final_comp_slope_accel_q};
            end else if (param_idx_in == vmd_pkg::IDX_FINAL_DECEL) begin
                rdata_d = {8'h00, final_comp_slope_decel_q};
            end else if (param_idx_in == vmd_pkg::IDX_THERMAL) begin
                rdata_d = {12'h000, thermal_comp_factor_q};
            end else if (param_idx_in == vmd_pkg::IDX_STALL_TH) begin
                rdata_d = stall_current_threshold_q;
            end else begin
                rdata_d = 16'h0000;
            end
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rdata_q <= 16'h0000;
            ack_q   <= 1'b0;
            err_q   <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            ack_q   <= ack_d;
            err_q   <= err_d;
        end
    end

    // Phase selects the duty level and the final slope.
    always_comb begin
        phase             = vmd_pkg::vmd_phase_t'(motion_phase_in);
        phase_final_slope = final_comp_slope_accel_q;
        case (phase)
            vmd_pkg::VMD_PH_HOLD: begin
                phase_duty = hold_duty_level_q;
            end
            vmd_pkg::VMD_PH_ACCEL: begin
                phase_duty = accel_duty_level_q;
            end
            vmd_pkg::VMD_PH_BRAKE: begin
                phase_duty        = decel_duty_level_q;
                phase_final_slope = final_comp_slope_decel_q;
            end
            default: begin
                phase_duty = run_duty_level_q;
            end
        endcase
    end

    vmd_bemf_comp #(
        .SPEED_W        (SPEED_W)
    ) u_bemf_comp (
        .duty_level_in  (phase_duty),
        .speed_in       (speed_q),
        .cross_in       (comp_crossover_speed_q),
        .start_slope_in (start_comp_slope_q),
        .final_slope_in (phase_final_slope),
        .therm_in       (thermal_comp_factor_q),
        .duty_out       (comp_duty),
        .above_out      (comp_above)
    );

    // Speed is sampled once per tick, the unit in which it is expressed.
    always_comb begin
        tick_cnt_d = tick_cnt_q - 1'b1;
        speed_d    = speed_q;
        if (tick_cnt_q == '0) begin
            tick_cnt_d = TICK_LAST;
            speed_d    = speed_in;
        end
        duty_d    = voltage_mode_in ? comp_duty : 8'h00;
        above_d   = voltage_mode_in && comp_above;
        stall_a_d = voltage_mode_in && stall_a_raw_in;
        stall_b_d = voltage_mode_in && stall_b_raw_in;
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tick_cnt_q <= TICK_LAST;
            speed_q    <= '0;
            duty_q     <= 8'h00;
            above_q    <= 1'b0;
            stall_a_q  <= 1'b0;
            stall_b_q  <= 1'b0;
        end else begin
            tick_cnt_q <= tick_cnt_d;
            speed_q    <= speed_d;
            duty_q     <= duty_d;
            above_q    <= above_d;
            stall_a_q  <= stall_a_d;
            stall_b_q  <= stall_b_d;
        end
    end

    // In current mode the modulator is held off; that stage is driven elsewhere.
    vmd_pwm #(
        .DUTY_W    (vmd_pkg::DUTY_W)
    ) u_pwm (
        .clk_in    (clk_in),
        .sys_rst_in(sys_rst_in),
        .enable_in (voltage_mode_in),
        .duty_in   (duty_q),
        .pwm_out   (pwm_out)
    );

    assign param_rdata_out     = rdata_q;
    assign param_ack_out       = ack_q;
    assign param_err_out       = err_q;
    assign stall_a_out         = stall_a_q;
    assign stall_b_out         = stall_b_q;
    assign stall_threshold_out = stall_current_threshold_q;
    assign duty_out            = duty_q;
    assign above_crossover_out = above_q;

endmodule : vmd_drive_params

// ==== verification/vmd_drive_params_assertions.sv ====
`timescale 1ns/1ps
module vmd_drive_params_chk (
    // Clock and reset.
    input wire logic        clk_in,
    input wire logic        sys_rst_in,
    // Parameter access port.
    input wire logic        param_wr_in,
    input wire logic        param_rd_in,
    input wire logic [7:0]  param_idx_in,
    input wire logic        param_ack_out,
    input wire logic        param_err_out,
    // Mode and stall.
    input wire logic        voltage_mode_in,
    input wire logic        stall_a_raw_in,
    input wire logic        stall_b_raw_in,
    input wire logic        stall_a_out,
    input wire logic        stall_b_out,
    input wire logic [15:0] stall_threshold_out,
    // Output stage.
    input wire logic [7:0]  duty_out,
    input wire logic        above_crossover_out,
    input wire logic        pwm_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    logic req;
    logic bad_idx;
    assign req = param_wr_in | param_rd_in;
    assign bad_idx = (param_idx_in < 8'h0A) || (param_idx_in > 8'h13);
    a_ack_after_req: assert property (req |=> param_ack_out && param_err_out == $past(bad_idx))
        else $error("ack or err wrong after request");
    a_ack_only_req: assert property (!req |=> !param_ack_out && !param_err_out)
        else $error("ack without request");
    a_stall_masked: assert property (!voltage_mode_in |=> !stall_a_out && !stall_b_out)
        else $error("stall flag seen in current mode");
    a_stall_pass: assert property (voltage_mode_in && stall_a_raw_in && stall_b_raw_in
        |=> stall_a_out && stall_b_out) else $error("stall flag lost in voltage mode");
    a_mode_quiet: assert property (!voltage_mode_in |=> duty_out == 8'h00 && !above_crossover_out)
        else $error("duty active in current mode");
    a_pwm_quiet: assert property (!voltage_mode_in |=> !pwm_out)
        else $error("pwm active in current mode");
    // The untouched reset value is the one threshold allowed off the grid.
    a_stall_grid: assert property (stall_threshold_out == 16'h40DA ||
        (stall_threshold_out % 16'h03D1 == 16'h0000 && stall_threshold_out >= 16'h03D1
        && stall_threshold_out <= 16'h764F)) else $error("stall threshold off grid");
    a_quiet_steady: assert property (!voltage_mode_in [*2] |=> $stable(duty_out))
        else $error("duty moved in current mode");
    c_stall_access: cover property (req && param_idx_in == 8'h13);
    c_above: cover property (above_crossover_out);
    c_stall_seen: cover property (stall_a_out && stall_b_out);
endmodule : vmd_drive_params_chk
bind vmd_drive_params vmd_drive_params_chk chk_u (.clk_in, .sys_rst_in, .param_wr_in,
    .param_rd_in, .param_idx_in, .param_ack_out, .param_err_out, .voltage_mode_in,
    .stall_a_raw_in, .stall_b_raw_in, .stall_a_out, .stall_b_out, .stall_threshold_out,
    .duty_out, .above_crossover_out, .pwm_out);

// ==== verification/vmd_bridge_model.sv ====
`timescale 1ns/1ps
module vmd_bridge_model (
    // Clock.
    input  wire logic       clk_in,
    // Bridge drive and stall control.
    input  wire logic       pwm_in,
    input  wire logic [1:0] stall_cmd_in,
    // Detector flags and measured mean voltage.
    output logic            stall_a_out,
    output logic            stall_b_out,
    output logic [8:0]      high_cnt_out
);
    logic [255:0] hist_q = '0;
    logic [255:0] hist_d;
    always_comb hist_d = {hist_q[254:0], pwm_in};
    always_ff @(posedge clk_in) hist_q <= hist_d;
    // A sliding 256-cycle window needs no phase lock to the modulator period.
    always_comb high_cnt_out = 9'($countones(hist_q));
    assign stall_a_out = stall_cmd_in[0];
    assign stall_b_out = stall_cmd_in[1];
endmodule : vmd_bridge_model

// ==== verification/vmd_drive_params_tb_top.sv ====
`timescale 1ns/1ps
module vmd_drive_params_tb_top;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic param_wr_in = 1'b0, param_rd_in = 1'b0, voltage_mode_in = 1'b1;
    logic [7:0] param_idx_in = 8'h00;
    logic [15:0] param_wdata_in = 16'h0000;
    logic [1:0] motion_phase_in = 2'h0, stall_cmd = 2'h0;
    logic [13:0] speed_in = 14'h0000;
    logic stall_a_raw_in, stall_b_raw_in, stall_a_out, stall_b_out;
    logic param_ack_out, param_err_out, above_crossover_out, pwm_out;
    logic [15:0] param_rdata_out, stall_threshold_out, rv;
    logic [7:0] duty_out;
    logic [8:0] high_cnt;
    int bad_count = 0, samples_checked = 0;
    logic [15:0] rst_tab [10] = '{16'h0005, 16'h0007, 16'h0007, 16'h0007, 16'h0F05,
        16'h000F, 16'h0017, 16'h0017, 16'h0000, 16'h40DA};
    logic [15:0] sw [3] = '{16'h40DA, 16'h0000, 16'hFFFF};
    logic [15:0] se [3] = '{16'h3D10, 16'h03D1, 16'h764F};
    logic [15:0] lvl [4] = '{16'h0040, 16'h0080, 16'h0021, 16'h0010};
    logic [1:0] ph [4] = '{2'h0, 2'h3, 2'h1, 2'h2};

    vmd_drive_params dut_u (.clk_in, .sys_rst_in, .param_wr_in, .param_rd_in, .param_idx_in,
        .param_wdata_in, .param_rdata_out, .param_ack_out, .param_err_out, .voltage_mode_in,
        .motion_phase_in, .speed_in, .stall_a_raw_in, .stall_b_raw_in, .stall_a_out,
        .stall_b_out, .stall_threshold_out, .duty_out, .above_crossover_out, .pwm_out);
    vmd_bridge_model bm_u (.clk_in, .pwm_in(pwm_out), .stall_cmd_in(stall_cmd),
        .stall_a_out(stall_a_raw_in), .stall_b_out(stall_b_raw_in), .high_cnt_out(high_cnt));

    initial begin
        forever #5 clk_in = ~clk_in;
    end

    task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk16

    task automatic chk1(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask : chk1

    task automatic access(input logic w, input logic [7:0] i, input logic [15:0] d,
        input logic e);
        @(negedge clk_in);
        param_wr_in = w;
        param_rd_in = !w;
        param_idx_in = i;
        param_wdata_in = d;
        @(negedge clk_in);
        param_wr_in = 1'b0;
        param_rd_in = 1'b0;
        chk1("ack", 1'b1, param_ack_out);
        chk1("err", e, param_err_out);
        rv = param_rdata_out;
    endtask : access

    task automatic wr(input logic [7:0] i, input logic [15:0] d);
        access(1'b1, i, d, 1'b0);
    endtask : wr

    task automatic rd_chk(input string what, input logic [7:0] i, input logic [15:0] e);
        access(1'b0, i, 16'h0000, 1'b0);
        chk16(what, e, rv);
    endtask : rd_chk

    task automatic op_chk(input logic [1:0] p, input logic [13:0] s, input logic [7:0] ed,
        input logic ea);
        @(negedge clk_in);
        motion_phase_in = p;
        speed_in = s;
        repeat (600) @(negedge clk_in);
        chk16("duty", {8'h00, ed}, {8'h00, duty_out});
        chk16("mean", {8'h00, ed}, {7'h00, high_cnt});
        chk1("above", ea, above_crossover_out);
    endtask : op_chk

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict

    initial begin
        #200us;
        bad_count++;
        print_verdict();
    end

    initial begin
        repeat (5) @(negedge clk_in);
        sys_rst_in = 1'b0;
        for (int i = 0; i < 10; i++) begin
            rd_chk("reset", 8'h0A + 8'(i), rst_tab[i]);
        end
        access(1'b0, 8'h14, 16'h0000, 1'b1);
        chk16("unmapped", 16'h0000, rv);
        access(1'b1, 8'h09, 16'hFFFF, 1'b1);
        rd_chk("hold_kept", 8'h0A, 16'h0005);
        $display("test reset done");
        wr(8'h12, 16'hFFFF);
        rd_chk("therm", 8'h12, 16'h000F);
        wr(8'h0E, 16'hFFFF);
        rd_chk("cross", 8'h0E, 16'h3FFF);
        for (int k = 0; k < 3; k++) begin
            wr(8'h13, sw[k]);
            rd_chk("stall_rd", 8'h13, se[k]);
            chk16("stall_out", se[k], stall_threshold_out);
        end
        $display("test access done");
        wr(8'h12, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            wr(8'h0A + 8'(i), lvl[i]);
        end
        for (int i = 0; i < 4; i++) begin
            op_chk(ph[i], 14'h0000, lvl[i][7:0], 1'b0);
        end
        wr(8'h12, 16'h000F);
        op_chk(2'h0, 14'h0000, 8'h5E, 1'b0);
        wr(8'h12, 16'h0000);
        wr(8'h0A, 16'h0000);
        op_chk(2'h0, 14'h0000, 8'h00, 1'b0);
        wr(8'h0A, 16'h00FF);
        op_chk(2'h0, 14'h0000, 8'hFF, 1'b0);
        wr(8'h0E, 16'h0200);
        wr(8'h0F, 16'h0010);
        wr(8'h10, 16'h0020);
        wr(8'h11, 16'h0010);
        op_chk(2'h1, 14'h0100, 8'h22, 1'b0);
        op_chk(2'h1, 14'h0300, 8'h25, 1'b1);
        op_chk(2'h2, 14'h0300, 8'h13, 1'b1);
        $display("test duty done");
        voltage_mode_in = 1'b0;
        stall_cmd = 2'h3;
        op_chk(2'h1, 14'h0300, 8'h00, 1'b0);
        chk1("stall_a", 1'b0, stall_a_out);
        chk1("stall_b", 1'b0, stall_b_out);
        voltage_mode_in = 1'b1;
        repeat (3) @(negedge clk_in);
        chk1("stall_a", 1'b1, stall_a_out);
        chk1("stall_b", 1'b1, stall_b_out);
        $display("test mode done");
        print_verdict();
    end
endmodule : vmd_drive_params_tb_top
